// *** design/vfvs_scaler.sv ***
// Line buffer, vertical scaler and horizontal fine scaler with register port
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module vfvs_scaler
    import vfvs_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          resetn_i,
    input  wire logic          ce_i,
    input  wire vfvs_bus_t     bus_i,
    output logic [7:0]         rdata_o,
    input  wire vfvs_pix_in_t  pix_i,
    output logic               in_ready_o,
    output vfvs_pix_out_t      pix_o,
    input  wire logic          out_ready_i
);

    vfvs_state_t               s_r;
    vfvs_state_t               s_nxt;

    logic [12:0]               h_inc_y;
    logic [12:0]               h_inc_c;
    logic [15:0]               v_inc_y;
    logic [15:0]               v_inc_c;
    logic                      mirror;
    logic                      multi_line_accumulation;
    logic [2:0]                dist_mask;
    logic [1:0]                sel;
    logic [7:0]                v_start_y;
    logic [7:0]                v_start_c;
    logic                      in_fire;
    logic                      c_wr;
    logic                      stall;
    logic [PIX_W-1:0]          ra;
    logic [1:0][7:0]           cur;
    logic [1:0][7:0]           prv;
    logic [1:0][5:0]           vph;
    logic [1:0][15:0]          lpi_sum;
    logic [1:0][8:0]           acc_sum;
    logic [1:0][7:0]           acc_sat;
    logic [1:0][7:0]           vpix;
    logic [5:0]                hph_y;
    logic [5:0]                hph_c;
    logic [LTAPS-1:0][15:0]    prod_y;
    logic [CTAPS-1:0][15:0]    prod_c;
    logic [19:0]               hsum_y;
    logic [19:0]               hsum_c;

    function automatic logic [6:0] hcoef(input int k, input int center, input logic [5:0] ph);
        logic [6:0] w;
        w = 7'h00;
        if (k == center) begin
            w = PH_FULL - {1'b0, ph};
        end else if (k == center - 1) begin
            w = {1'b0, ph};
        end
        return w;
    endfunction

    assign h_inc_y   = {s_r.regs[RI_HYI_HI][4:0], s_r.regs[RI_HYI_LO]};
    assign h_inc_c   = {s_r.regs[RI_HCI_HI][4:0], s_r.regs[RI_HCI_LO]};
    assign v_inc_y   = {s_r.regs[RI_VYI_HI], s_r.regs[RI_VYI_LO]};
    assign v_inc_c   = {s_r.regs[RI_VCI_HI], s_r.regs[RI_VCI_LO]};
    assign mirror    = s_r.regs[RI_VMODE][MIRROR_BIT];
    assign multi_line_accumulation       = s_r.regs[RI_VMODE][MODE_BIT];
    assign sel       = {s_r.buf_fid, s_r.buf_task};
    assign v_start_y = s_r.regs[RI_VY_START0 + int'(sel)];
    assign v_start_c = s_r.regs[RI_VC_START0 + int'(sel)];

    // Chroma group size from the line distance field: 1, 2, 4 or 8 lines
    always_comb begin
        case (s_r.regs[RI_YC_DIST][YC_DIST_LSB +: 2])
            2'b00:   dist_mask = 3'h0;
            2'b01:   dist_mask = 3'h1;
            2'b10:   dist_mask = 3'h3;
            default: dist_mask = 3'h7;
        endcase
    end

    assign in_fire = pix_i.valid && s_r.in_ready;
    assign c_wr    = ((pix_i.sof ? 3'h0 : s_r.line_cnt) & dist_mask) == 3'h0;
    assign stall   = s_r.out.valid && !out_ready_i;
    assign ra      = mirror ? PIX_W'(s_r.len - s_r.rptr - 10'd1) : s_r.rptr;

    // Vertical filter, one instance per component (0 luma, 1 chroma)
    generate
        for (genvar g = 0; g < 2; g++) begin : g_vert
            assign cur[g]     = (g == 0) ? s_r.buf_y[ra] : s_r.buf_c[ra];
            assign prv[g]     = (g == 0) ? s_r.dly_y[ra] : s_r.dly_c[ra];
            assign vph[g]     = (g == 0) ? s_r.vrel_y[9:4] : s_r.vrel_c[9:4];
            assign lpi_sum[g] = {8'h00, prv[g]} * {9'h000, PH_FULL - {1'b0, vph[g]}}
                              + {8'h00, cur[g]} * {9'h000, 1'b0, vph[g]};
            assign acc_sum[g] = {1'b0, prv[g]} + {1'b0, cur[g]};
            assign acc_sat[g] = acc_sum[g][8] ? 8'hff : acc_sum[g][7:0];
            assign vpix[g]    = multi_line_accumulation ? acc_sat[g] : lpi_sum[g][13:6];
        end
    endgenerate

    assign hph_y = s_r.hacc[9:4];
    assign hph_c = s_r.cacc[8:3];

    generate
        for (genvar k = 0; k < LTAPS; k++) begin : g_ltap
            assign prod_y[k] = {8'h00, s_r.tap_y[k]} * {9'h000, hcoef(k, LCENTER, hph_y)};
        end
        for (genvar k = 0; k < CTAPS; k++) begin : g_ctap
            assign prod_c[k] = {8'h00, s_r.tap_c[k]} * {9'h000, hcoef(k, CCENTER, hph_c)};
        end
    endgenerate

    // Tap sums of the horizontal filters
    always_comb begin
        hsum_y = 20'h00000;
        hsum_c = 20'h00000;
        for (int k = 0; k < LTAPS; k++) begin
            hsum_y = hsum_y + {4'h0, prod_y[k]};
        end
        for (int k = 0; k < CTAPS; k++) begin
            hsum_c = hsum_c + {4'h0, prod_c[k]};
        end
    end

    always_comb begin
        s_nxt           = s_r;
        s_nxt.rdata     = 8'h00;
        s_nxt.out.eol   = 1'b0;
        s_nxt.out.valid = s_r.out.valid && !out_ready_i;

        // Register port
        for (int i = 0; i < REG_RW_N; i++) begin
            if (bus_i.wr && bus_i.addr == REG_OFF[i]) begin
                s_nxt.regs[i] = bus_i.wdata;
            end
            if (bus_i.rd && bus_i.addr == REG_OFF[i]) begin
                s_nxt.rdata = s_r.regs[i];
            end
        end
        if (bus_i.rd && bus_i.addr == OFF_STATUS) begin
            s_nxt.rdata = {4'h0, multi_line_accumulation, s_r.buf_full, s_r.task_bit, s_r.field_id};
        end

        // Write side of the line buffer
        if (in_fire) begin
            if (s_r.wptr < PIX_W'(LINE_PIX)) begin
                s_nxt.buf_y[s_r.wptr] = pix_i.y;
                if (c_wr) begin
                    s_nxt.buf_c[s_r.wptr] = pix_i.c;
                end
                s_nxt.wptr = s_r.wptr + 10'd1;
            end
            if (pix_i.sof) begin
                s_nxt.buf_sof  = 1'b1;
                s_nxt.buf_fid  = pix_i.field_id;
                s_nxt.buf_task = pix_i.task_bit;
                s_nxt.line_cnt = 3'h0;
            end
            if (pix_i.eol) begin
                s_nxt.buf_full = 1'b1;
                s_nxt.len      = s_nxt.wptr;
                s_nxt.wptr     = 10'd0;
                s_nxt.line_cnt = s_nxt.line_cnt + 3'h1;
            end
        end

        // Read side: one pass over the stored line per output or absorbed line
        case (s_r.pstate)
            VF_IDLE: begin
                if (s_r.buf_full && !stall) begin
                    if (s_r.buf_sof) begin
                        s_nxt.vrel_y   = {5'h00, v_start_y, 5'h00};
                        s_nxt.vrel_c   = {5'h00, v_start_c, 5'h00};
                        s_nxt.field_id = s_r.buf_fid;
                        s_nxt.task_bit = s_r.buf_task;
                        s_nxt.buf_sof  = 1'b0;
                    end
                    s_nxt.emit   = s_nxt.vrel_y < V_UNITY;
                    s_nxt.rptr   = 10'd0;
                    s_nxt.hacc   = H_PRELOAD + {1'b0, s_r.regs[RI_HY_PH], 5'h00};
                    s_nxt.cacc   = C_PRELOAD + {1'b0, s_r.regs[RI_HC_PH], 5'h00};
                    s_nxt.pstate = VF_PASS;
                end
            end
            VF_PASS: begin
                if (!stall) begin
                    if (s_r.emit && s_r.hacc < H_UNITY) begin
                        s_nxt.out.valid = 1'b1;
                        s_nxt.out.y     = hsum_y[13:6];
                        s_nxt.out.c     = hsum_c[13:6];
                        s_nxt.hacc      = s_r.hacc + {1'b0, h_inc_y};
                        s_nxt.cacc      = s_r.cacc + {1'b0, h_inc_c};
                    end else if (s_r.rptr == s_r.len) begin
                        s_nxt.pstate  = VF_IDLE;
                        s_nxt.out.eol = s_r.emit;
                        if (s_r.emit && !multi_line_accumulation) begin
                            // Same line stays for the next output line
                            s_nxt.vrel_y = s_r.vrel_y + {2'h0, v_inc_y};
                            s_nxt.vrel_c = s_r.vrel_c + {2'h0, v_inc_c};
                        end else begin
                            s_nxt.vrel_y   = s_r.vrel_y + (s_r.emit ? {2'h0, v_inc_y} : 18'h0)
                                           - V_UNITY;
                            s_nxt.vrel_c   = s_r.vrel_c + (s_r.emit ? {2'h0, v_inc_c} : 18'h0)
                                           - V_UNITY;
                            s_nxt.buf_full = 1'b0;
                        end
                    end else begin
                        if (multi_line_accumulation) begin
                            s_nxt.dly_y[ra] = s_r.emit ? 8'h00 : acc_sat[0];
                            s_nxt.dly_c[ra] = s_r.emit ? 8'h00 : acc_sat[1];
                        end else if (!s_r.emit) begin
                            s_nxt.dly_y[ra] = cur[0];
                            s_nxt.dly_c[ra] = cur[1];
                        end
                        if (s_r.emit) begin
                            for (int k = LTAPS - 1; k > 0; k--) begin
                                s_nxt.tap_y[k] = s_r.tap_y[k-1];
                            end
                            for (int k = CTAPS - 1; k > 0; k--) begin
                                s_nxt.tap_c[k] = s_r.tap_c[k-1];
                            end
                            s_nxt.tap_y[0] = vpix[0];
                            s_nxt.tap_c[0] = vpix[1];
                            s_nxt.hacc     = s_r.hacc - H_UNITY;
                            s_nxt.cacc     = s_r.cacc - C_STEP;
                        end
                        s_nxt.rptr = s_r.rptr + 10'd1;
                    end
                end
            end
            default: begin
                s_nxt.pstate = VF_IDLE;
            end
        endcase

        s_nxt.in_ready = !s_nxt.buf_full;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= VFVS_STATE_RST;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o    = s_r.rdata;
    assign in_ready_o = s_r.in_ready;
    assign pix_o      = s_r.out;

endmodule

// *** design/vfvs_pkg.sv ***
// Constants, register map and carrier types of the fine and vertical scaler
package vfvs_pkg;

    localparam int LINE_PIX = 768;
    localparam int PIX_W    = 10;
    localparam int LTAPS    = 10;
    localparam int CTAPS    = 4;
    localparam int LCENTER  = 5;
    localparam int CCENTER  = 2;
    localparam int PH_BITS  = 6;
    localparam int PH_SHIFT = 5;
    localparam int YC_DIST_LSB = 1;
    localparam int MIRROR_BIT  = 4;
    localparam int MODE_BIT    = 0;

    localparam int REG_RW_N = 22;
    localparam logic [7:0] REG_OFF [REG_RW_N] = '{
        8'h91, 8'ha5, 8'ha6, 8'ha8, 8'ha9, 8'haa, 8'hac, 8'had, 8'hae,
        8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb4,
        8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf};
    localparam logic [7:0] REG_RST [REG_RW_N] = '{
        8'h00, 8'h40, 8'h40, 8'h00, 8'h04, 8'h00, 8'h00, 8'h02, 8'h00,
        8'h00, 8'h04, 8'h00, 8'h04, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] OFF_STATUS = 8'hc2;

    localparam int RI_YC_DIST   = 0;
    localparam int RI_HYI_LO    = 3;
    localparam int RI_HYI_HI    = 4;
    localparam int RI_HY_PH     = 5;
    localparam int RI_HCI_LO    = 6;
    localparam int RI_HCI_HI    = 7;
    localparam int RI_HC_PH     = 8;
    localparam int RI_VYI_LO    = 9;
    localparam int RI_VYI_HI    = 10;
    localparam int RI_VCI_LO    = 11;
    localparam int RI_VCI_HI    = 12;
    localparam int RI_VMODE     = 13;
    localparam int RI_VC_START0 = 14;
    localparam int RI_VY_START0 = 18;

    localparam logic [17:0] V_UNITY   = 18'h00400;
    localparam logic [13:0] H_UNITY   = 14'h0400;
    localparam logic [13:0] C_STEP    = 14'h0200;
    localparam logic [13:0] H_PRELOAD = 14'h1800;
    localparam logic [13:0] C_PRELOAD = 14'h0c00;
    localparam logic [6:0]  PH_FULL   = 7'h40;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } vfvs_bus_t;

    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eol;
        logic       field_id;
        logic       task_bit;
        logic [7:0] y;
        logic [7:0] c;
    } vfvs_pix_in_t;

    typedef struct packed {
        logic       valid;
        logic       eol;
        logic [7:0] y;
        logic [7:0] c;
    } vfvs_pix_out_t;

    typedef enum logic [0:0] {VF_IDLE, VF_PASS} vfvs_pass_t;

    typedef struct packed {
        logic [REG_RW_N-1:0][7:0] regs;
        logic [LINE_PIX-1:0][7:0] buf_y;
        logic [LINE_PIX-1:0][7:0] buf_c;
        logic [LINE_PIX-1:0][7:0] dly_y;
        logic [LINE_PIX-1:0][7:0] dly_c;
        logic                     buf_full;
        logic                     buf_sof;
        logic                     buf_fid;
        logic                     buf_task;
        logic [PIX_W-1:0]         wptr;
        logic [PIX_W-1:0]         len;
        logic [2:0]               line_cnt;
        vfvs_pass_t               pstate;
        logic                     emit;
        logic [PIX_W-1:0]         rptr;
        logic [17:0]              vrel_y;
        logic [17:0]              vrel_c;
        logic                     field_id;
        logic                     task_bit;
        logic [LTAPS-1:0][7:0]    tap_y;
        logic [CTAPS-1:0][7:0]    tap_c;
        logic [13:0]              hacc;
        logic [13:0]              cacc;
        vfvs_pix_out_t            out;
        logic                     in_ready;
        logic [7:0]               rdata;
    } vfvs_state_t;

    function automatic vfvs_state_t vfvs_reset_state();
        vfvs_state_t s;
        s = '0;
        for (int i = 0; i < REG_RW_N; i++) begin
            s.regs[i] = REG_RST[i];
        end
        s.in_ready = 1'b1;
        return s;
    endfunction

    localparam vfvs_state_t VFVS_STATE_RST = vfvs_reset_state();

endpackage

// *** tb/vfvs_monitor.sv ***
// Port-level assertions for the fine and vertical scaler
`timescale 1ns/10ps
module vfvs_monitor
    import vfvs_pkg::*;
(
    input wire logic          clk_i,
    input wire logic          resetn_i,
    input wire logic          ce_i,
    input wire vfvs_bus_t     bus_i,
    input wire logic [7:0]    rdata_o,
    input wire vfvs_pix_in_t  pix_i,
    input wire logic          in_ready_o,
    input wire vfvs_pix_out_t pix_o,
    input wire logic          out_ready_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence phase_write_then_read;
        ce_i && bus_i.wr && bus_i.addr[7:3] == 5'h17 ##1
        ce_i && bus_i.rd && bus_i.addr == $past(bus_i.addr);
    endsequence
    sequence line_taken;
        ce_i && pix_i.valid && in_ready_o && pix_i.eol;
    endsequence
    a_rdata_idle: assert property ($past(ce_i) && !$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not cleared");
    a_phase_readback: assert property (phase_write_then_read |=> rdata_o == $past(bus_i.wdata, 2))
        else $error("start phase readback wrong");
    a_unmapped_read: assert property (ce_i && bus_i.rd && bus_i.addr > 8'hc2 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_status_spare: assert property (ce_i && bus_i.rd && bus_i.addr == OFF_STATUS |=> rdata_o[7:4] == 4'h0)
        else $error("status spare bits set");
    a_line_hold: assert property (line_taken |=> !in_ready_o)
        else $error("input not held after line end");
    a_out_stall: assert property (pix_o.valid && !out_ready_i |=> pix_o.valid && $stable(pix_o.y) && $stable(pix_o.c))
        else $error("output changed while stalled");
    a_eol_gap: assert property (pix_o.eol |-> !pix_o.valid)
        else $error("line end beside valid pixel");
    a_eol_pulse: assert property (ce_i && pix_o.eol |=> !pix_o.eol)
        else $error("line end longer than one cycle");
    a_reset_quiet: assert property ($rose(resetn_i) |-> in_ready_o && !pix_o.valid)
        else $error("wrong state after reset");
endmodule

// *** tb/vfvs_partner.sv ***
// Upstream pixel source and downstream sink around the scaler
`timescale 1ns/10ps
module vfvs_partner
    import vfvs_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          resetn_i,
    input  wire logic          in_ready_i,
    input  wire vfvs_pix_out_t pix_i,
    input  wire logic          stall_i,
    output vfvs_pix_in_t       pix_o,
    output logic               out_ready_o
);
    logic [7:0] first_y [64];
    logic [7:0] first_c [64];
    logic [7:0] last_y  [64];
    int         lines_seen;
    int         pix_seen;
    logic       toggle_r;

    initial pix_o = '0;

    // Each pixel stays on the lines until the edge that takes it
    task automatic send_field(input int npix, input int nl, input logic fid, input logic tb);
        for (int l = 0; l < nl; l++) begin
            for (int p = 0; p < npix; p++) begin
                pix_o <= '{1'b1, l == 0 && p == 0, p == npix - 1, fid, tb,
                           8'(p * 16 + l), 8'(8'h40 + l * 16 + p)};
                do @(negedge clk_i); while (!in_ready_i);
                @(posedge clk_i);
            end
        end
        // Released data lines show the inverse of the last sample
        pix_o <= '{1'b0, 1'b0, 1'b0, fid, tb, ~pix_o.y, ~pix_o.c};
    endtask

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            toggle_r    <= 1'b0;
            out_ready_o <= 1'b0;
            lines_seen  <= 0;
            pix_seen    <= 0;
        end else begin
            toggle_r    <= ~toggle_r;
            out_ready_o <= !stall_i || toggle_r;
            if (pix_i.valid && out_ready_o) begin
                if (pix_seen == 0) begin
                    first_y[lines_seen[5:0]] <= pix_i.y;
                    first_c[lines_seen[5:0]] <= pix_i.c;
                end
                last_y[lines_seen[5:0]] <= pix_i.y;
                pix_seen <= pix_seen + 1;
            end
            if (pix_i.eol) begin
                lines_seen <= lines_seen + 1;
                pix_seen   <= 0;
            end
        end
    end
endmodule

// *** tb/test_video_fine_and_vertical_scaler.sv ***
// Self-checking bench for the fine and vertical scaler
`timescale 1ns/10ps
module test_video_fine_and_vertical_scaler
    import vfvs_pkg::*;
;
    logic          clk_i = 1'b0;
    logic          resetn_i = 1'b0;
    vfvs_bus_t     bus_i = '0;
    logic [7:0]    rdata_o;
    vfvs_pix_in_t  pix_i;
    logic          in_ready_o;
    vfvs_pix_out_t pix_o;
    logic          out_ready_i;
    logic          stall = 1'b0;
    logic          ce = 1'b1;
    logic [7:0]    d;
    int            fail_count = 0;
    int            total_checks = 0;
    int            base;

    always #2.5 clk_i = ~clk_i;

    vfvs_scaler vfvs_scaler_i (.clk_i, .resetn_i, .ce_i(ce), .bus_i, .rdata_o, .pix_i,
                               .in_ready_o, .pix_o, .out_ready_i);
    vfvs_partner vfvs_partner_i (.clk_i, .resetn_i, .in_ready_i(in_ready_o), .pix_i(pix_o),
                                 .stall_i(stall), .pix_o(pix_i), .out_ready_o(out_ready_i));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Bus tasks start right after a rising edge; wr_reg leaves the strobe to the next call, set_reg and rd_reg clear it
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        bus_i <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_i);
    endtask

    task automatic set_reg(input logic [7:0] a, input logic [7:0] v);
        wr_reg(a, v);
        bus_i <= '0;
        @(posedge clk_i);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        bus_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        @(negedge clk_i);
        d = rdata_o;
        @(posedge clk_i);
    endtask

    task automatic run_field(input int nl, input logic fid, input logic tb, input int exp);
        int n;
        base = vfvs_partner_i.lines_seen;
        vfvs_partner_i.send_field(8, nl, fid, tb);
        n = 0;
        @(negedge clk_i);
        while (!in_ready_o && n < 4000) begin
            @(negedge clk_i);
            n++;
        end
        repeat (4) @(posedge clk_i);
        check(16'(vfvs_partner_i.lines_seen - base), 16'(n < 4000 ? exp : -1));
    endtask

    task automatic t_registers();
        for (int i = 0; i < REG_RW_N; i++) begin
            rd_reg(REG_OFF[i]);
            check(16'(d), 16'(REG_RST[i]));
            wr_reg(REG_OFF[i], ~REG_RST[i]);
            rd_reg(REG_OFF[i]);
            check(16'(d), {8'h00, ~REG_RST[i]});
            set_reg(REG_OFF[i], REG_RST[i]);
        end
        set_reg(OFF_STATUS, 8'hff);
        rd_reg(OFF_STATUS);
        check(16'(d[7:4]), 16'h0);
        rd_reg(8'hc3);
        check(16'(d), 16'h0);
        // A write while the clock enable is low must leave the register alone
        ce <= 1'b0;
        set_reg(8'hb8, 8'h5a);
        ce <= 1'b1;
        rd_reg(8'hb8);
        check(16'(d), 16'h0000);
    endtask

    task automatic t_modes();
        run_field(4, 1'b0, 1'b0, 4);
        check(16'(vfvs_partner_i.first_y[base + 1] < vfvs_partner_i.last_y[base + 1]),
              16'h1);
        set_reg(8'hb1, 8'h02);
        set_reg(8'hb3, 8'h02);
        run_field(4, 1'b0, 1'b0, 8);
        set_reg(8'hb4, 8'h01);
        set_reg(8'hb1, 8'h08);
        set_reg(8'hb3, 8'h08);
        set_reg(8'ha5, 8'h20);
        set_reg(8'ha6, 8'h20);
        run_field(8, 1'b0, 1'b0, 4);
        set_reg(8'hb1, 8'h04);
        set_reg(8'hb3, 8'h04);
        set_reg(8'hb4, 8'h10);
        run_field(2, 1'b0, 1'b0, 2);
        check(16'(vfvs_partner_i.first_y[base + 1] > vfvs_partner_i.last_y[base + 1]),
              16'h1);
        set_reg(8'hb4, 8'h00);
        // Horizontal zoom by two with a half-pixel offset, chroma kept at half rate
        set_reg(8'ha9, 8'h02);
        set_reg(8'had, 8'h01);
        set_reg(8'haa, 8'h10);
        set_reg(8'hae, 8'h08);
        run_field(2, 1'b0, 1'b0, 2);
        check(16'(vfvs_partner_i.first_y[base + 1]), 16'h0008);
        set_reg(8'ha9, 8'h04);
        set_reg(8'had, 8'h02);
        set_reg(8'haa, 8'h00);
        set_reg(8'hae, 8'h00);
    endtask

    task automatic t_phase_stall_chroma();
        set_reg(8'hbe, 8'h20);
        set_reg(8'hba, 8'h20);
        run_field(4, 1'b1, 1'b0, 3);
        rd_reg(OFF_STATUS);
        check(16'(d[1:0]), 16'h1);
        run_field(4, 1'b0, 1'b1, 4);
        rd_reg(OFF_STATUS);
        check(16'(d[1:0]), 16'h2);
        set_reg(8'hbe, 8'h00);
        set_reg(8'hba, 8'h00);
        stall <= 1'b1;
        run_field(4, 1'b0, 1'b0, 4);
        stall <= 1'b0;
        set_reg(8'h91, 8'h02);
        run_field(4, 1'b0, 1'b0, 4);
        check(16'(vfvs_partner_i.first_c[base + 2]),
              16'(vfvs_partner_i.first_c[base + 1]));
        check(16'(vfvs_partner_i.first_c[base + 3] !== vfvs_partner_i.first_c[base + 2]),
              16'h1);
        set_reg(8'h91, 8'h00);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        t_registers();
        t_modes();
        t_phase_stall_chroma();
        end_of_test();
    end

    initial begin
        #100us;
        fail_count++;
        end_of_test();
    end
endmodule

bind vfvs_scaler vfvs_monitor vfvs_monitor_i (.clk_i, .resetn_i, .ce_i, .bus_i, .rdata_o,
                                              .pix_i, .in_ready_o, .pix_o, .out_ready_i);
